// >>> rtl/adc_ctrl_pkg.sv
// Package with register map, field positions, reset values and timing for the converter control.
package adc_ctrl_pkg;
    // Register indices on the plain register port.
    localparam logic [2:0] OFS_RESULT_LOW = 3'h0;
    localparam logic [2:0] OFS_RESULT_HIGH = 3'h1;
    localparam logic [2:0] OFS_CONTROL_MAIN = 3'h2;
    localparam logic [2:0] OFS_SOURCE_CLOCK = 3'h3;
    localparam logic [2:0] OFS_MODE_SENSOR = 3'h4;
    localparam logic [2:0] OFS_BANDGAP = 3'h5;
    localparam logic [2:0] OFS_IRQ_STATUS = 3'h6;
    localparam logic [2:0] OFS_IRQ_MASK = 3'h7;

    // Field positions of the main control register.
    localparam int BIT_START = 7;
    localparam int BIT_BUSY = 6;
    localparam int BIT_ENABLE = 5;
    localparam int BIT_ALIGN = 4;
    // Field positions of the source and clock register.
    localparam int SRC_HI = 7;
    localparam int SRC_LO = 5;
    localparam int REF_HI = 4;
    localparam int REF_LO = 3;
    localparam int DIV_HI = 2;
    localparam int DIV_LO = 0;
    // Field positions of the mode and sensor register, and of the bandgap register.
    localparam int BIT_MODE = 7;
    localparam int BIT_RSVD = 1;
    localparam int BIT_TEMP_SENSOR_ENABLE = 0;
    localparam int BIT_BGEN = 0;
    // Interrupt status bits.
    localparam int IRQ_DONE = 0;
    localparam int IRQ_BAD_SRC = 1;

    // Reset values.
    localparam logic [7:0] RST_CONTROL_MAIN = 8'h00;
    localparam logic [7:0] RST_SOURCE_CLOCK = 8'h00;
    localparam logic [7:0] RST_MODE_SENSOR = 8'h02;
    localparam logic [7:0] RST_BANDGAP = 8'h00;
    localparam logic [11:0] RST_RESULT = 12'h000;

    // Input source codes.
    localparam logic [2:0] SRC_EXT = 3'h0;
    localparam logic [2:0] SRC_BANDGAP = 3'h1;
    localparam logic [2:0] SRC_TEMP = 3'h2;
    localparam logic [2:0] SRC_AMP_OUT = 3'h3;
    localparam logic [2:0] SRC_AMP_POS = 3'h4;
    localparam logic [2:0] SRC_FORBIDDEN = 3'h7;

    // Reference codes.
    localparam logic [1:0] REF_PIN_LDO = 2'h0;
    localparam logic [1:0] REF_TEMP = 2'h2;

    // Conversion length in conversion-clock cycles, one per result bit plus sampling.
    localparam int CONV_CYCLES = 16;
    localparam logic [4:0] CONV_LAST = 5'(CONV_CYCLES - 1);
    localparam int RESULT_BITS = 12;
endpackage

// >>> rtl/conv_clock_div.sv
// Conversion clock divider producing a one-cycle tick every 2^code system clocks.
module conv_clock_div
    import adc_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic run,
    input wire logic [2:0] div_code,
    output logic tick
);
    logic [6:0] cnt_ff;
    logic [6:0] nxt_cnt;
    wire logic [6:0] limit = 7'((8'h01 << div_code) - 8'h01);
    wire logic at_limit = (cnt_ff >= limit);

    // Tick on the last count of each period; code 0 ticks on every edge.
    assign tick = run && at_limit;
    assign nxt_cnt = (!run || at_limit) ? 7'h00 : 7'(cnt_ff + 7'h01);

    // Counter held at zero while idle so every conversion starts on a whole period.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 7'h00;
        end else begin
            cnt_ff <= nxt_cnt;
        end
    end
endmodule

// >>> rtl/adc_control_regs.sv
// Register file, start sequencing, source routing and result handling of the converter.
// Operation
// - Result is 12 bits held in read-only high and low byte registers.
// - Alignment 0 gives high=11..4, low=3..0 on top; 1 gives high=11..8, low=7..0.
// - Result bit positions unused by the chosen alignment read zero.
// - With converter disabled, both result registers keep their last value.
// - Conversion starts only after start bit written high then low.
// - Busy flag sets when start completes, clears at conversion end, ignores writes.
// - Enable bit powers converter; cleared it switches converter off.
// - Four-bit external channel select in main control register routes an input pin.
// - Three-bit source field picks internal signal or selected external channel.
// - Internal sources bandgap, temperature, amplifier output and positive input; eight pins.
// - Second register holds reference field bits 4..3, divider bits 2..0.
// - Separate register bit 0 enables bandgap reference output to converter.
// - Source codes map as listed; code 111 must never be written.
// - Channel codes 0..7 pick pins 0..7; 8..15 connect no pin.
// - Divider codes 0..7 give system clock over 1 to 128.
// - Reference codes 00 pin or regulator, 01 and 11 supply, 10 sensor.
module adc_control_regs
    import adc_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic irq,
    output logic conv_power_on,
    output logic sample_hold,
    input wire logic comp_in,
    output logic [7:0] ext_pin_sel,
    output logic [3:0] int_src_sel,
    output logic [2:0] ref_sel,
    output logic low_current_mode,
    output logic temp_sensor_enable,
    output logic bandgap_enable
);
    typedef enum logic [1:0] {ST_IDLE, ST_CONVERT, ST_FINISH} conv_state_e;

    conv_state_e state_ff;
    conv_state_e nxt_state;
    logic [7:0] main_ff;
    logic [7:0] srcclk_ff;
    logic [7:0] mode_ff;
    logic bgen_ff;
    logic [11:0] result_ff;
    logic [11:0] sar_ff;
    logic [11:0] nxt_sar;
    logic [4:0] step_ff;
    logic [4:0] nxt_step;
    logic [1:0] irq_stat_ff;
    logic [1:0] irq_mask_ff;
    logic [7:0] rdata_ff;
    logic comp_meta_ff;
    logic comp_sync_ff;
    logic tick;

    // Named fields of the control registers.
    wire logic converter_enable = main_ff[BIT_ENABLE];
    wire logic result_alignment_sel = main_ff[BIT_ALIGN];
    wire logic start_bit = main_ff[BIT_START];
    wire logic [3:0] external_channel_sel = main_ff[3:0];
    wire logic [2:0] input_source_sel = srcclk_ff[SRC_HI:SRC_LO];
    wire logic [1:0] reference_source_sel = srcclk_ff[REF_HI:REF_LO];
    wire logic [2:0] conv_clock_divider = srcclk_ff[DIV_HI:DIV_LO];
    wire logic conv_busy_flag = (state_ff != ST_IDLE);

    // Register decode.
    wire logic wr_main = reg_wr && (reg_addr == OFS_CONTROL_MAIN);
    wire logic wr_src = reg_wr && (reg_addr == OFS_SOURCE_CLOCK);
    wire logic wr_mode = reg_wr && (reg_addr == OFS_MODE_SENSOR);
    wire logic wr_bg = reg_wr && (reg_addr == OFS_BANDGAP);
    wire logic wr_stat = reg_wr && (reg_addr == OFS_IRQ_STATUS);
    wire logic wr_mask = reg_wr && (reg_addr == OFS_IRQ_MASK);

    // Start completes on the write that takes a set start bit low again.
    wire logic start_done = wr_main && start_bit && !reg_wdata[BIT_START];
    wire logic launch = start_done && converter_enable && !conv_busy_flag;
    // A conversion ends when the last step retires.
    wire logic conv_end = (state_ff == ST_FINISH);
    // Writing the forbidden source code is rejected and flagged.
    wire logic bad_src = wr_src && (reg_wdata[SRC_HI:SRC_LO] == SRC_FORBIDDEN);

    // Result alignment views; unused positions are tied to zero.
    wire logic [7:0] res_high = result_alignment_sel ? {4'h0, result_ff[11:8]}
                                                     : result_ff[11:4];
    wire logic [7:0] res_low = result_alignment_sel ? result_ff[7:0]
                                                    : {result_ff[3:0], 4'h0};
    wire logic [7:0] rd_mux =
        (reg_addr == OFS_RESULT_LOW) ? res_low :
        (reg_addr == OFS_RESULT_HIGH) ? res_high :
        (reg_addr == OFS_CONTROL_MAIN) ? {main_ff[7], conv_busy_flag, main_ff[5:0]} :
        (reg_addr == OFS_SOURCE_CLOCK) ? srcclk_ff :
        (reg_addr == OFS_MODE_SENSOR) ? mode_ff :
        (reg_addr == OFS_BANDGAP) ? {7'h00, bgen_ff} :
        (reg_addr == OFS_IRQ_STATUS) ? {6'h00, irq_stat_ff} : {6'h00, irq_mask_ff};

    // Analog routing: the pin one-hot is empty for codes 8..15 or an internal source.
    wire logic src_is_ext = (input_source_sel == SRC_EXT) || (input_source_sel > SRC_AMP_POS);
    assign ext_pin_sel = (src_is_ext && !external_channel_sel[3])
                         ? 8'(8'h01 << external_channel_sel[2:0]) : 8'h00;
    assign int_src_sel[0] = (input_source_sel == SRC_BANDGAP);
    assign int_src_sel[1] = (input_source_sel == SRC_TEMP);
    assign int_src_sel[2] = (input_source_sel == SRC_AMP_OUT);
    assign int_src_sel[3] = (input_source_sel == SRC_AMP_POS);
    // Reference one-hot: pin/regulator, sensor reference, otherwise converter supply.
    assign ref_sel[0] = (reference_source_sel == REF_PIN_LDO);
    assign ref_sel[1] = (reference_source_sel == REF_TEMP);
    assign ref_sel[2] = reference_source_sel[0];
    assign conv_power_on = converter_enable;
    assign low_current_mode = mode_ff[BIT_MODE];
    assign temp_sensor_enable = mode_ff[BIT_TEMP_SENSOR_ENABLE];
    assign bandgap_enable = bgen_ff;
    assign sample_hold = (state_ff == ST_CONVERT) && (step_ff < 5'(CONV_CYCLES - RESULT_BITS));
    assign reg_rdata = rdata_ff;
    assign irq = |(irq_stat_ff & irq_mask_ff);

    conv_clock_div u_div (
        .mclk(mclk),
        .arst_n(arst_n),
        .run(state_ff == ST_CONVERT),
        .div_code(conv_clock_divider),
        .tick(tick)
    );

    // Conversion sequencer; disabling the converter abandons the conversion unharmed.
    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_sar = sar_ff;
        case (state_ff)
            ST_IDLE: begin
                if (launch) begin
                    nxt_state = ST_CONVERT;
                    nxt_step = 5'h00;
                    nxt_sar = 12'h000;
                end
            end
            ST_CONVERT: begin
                if (!converter_enable) begin
                    nxt_state = ST_IDLE;
                end else if (tick) begin
                    nxt_step = 5'(step_ff + 5'h01);
                    if (!sample_hold) begin
                        nxt_sar = {sar_ff[10:0], comp_sync_ff};
                    end
                    if (step_ff == CONV_LAST) begin
                        nxt_state = ST_FINISH;
                    end
                end
            end
            ST_FINISH: begin
                nxt_state = ST_IDLE;
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    // Sequencer state, comparator synchroniser and read data.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= ST_IDLE;
            step_ff <= 5'h00;
            sar_ff <= RST_RESULT;
            comp_meta_ff <= 1'b0;
            comp_sync_ff <= 1'b0;
            rdata_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            sar_ff <= nxt_sar;
            comp_meta_ff <= comp_in;
            comp_sync_ff <= comp_meta_ff;
            rdata_ff <= reg_rd ? rd_mux : 8'h00;
        end
    end

    // Result latches only at conversion end and only while enabled.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            result_ff <= RST_RESULT;
        end else if (conv_end && converter_enable) begin
            result_ff <= sar_ff;
        end
    end

    // Control registers; the busy bit is never stored and the reserved bit stays one.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            main_ff <= RST_CONTROL_MAIN;
            srcclk_ff <= RST_SOURCE_CLOCK;
            mode_ff <= RST_MODE_SENSOR;
            bgen_ff <= RST_BANDGAP[BIT_BGEN];
        end else begin
            if (wr_main) begin
                main_ff <= {reg_wdata[7], 1'b0, reg_wdata[5:0]};
            end
            if (wr_src && !bad_src) begin
                srcclk_ff <= reg_wdata;
            end
            if (wr_mode) begin
                mode_ff <= {reg_wdata[BIT_MODE], 5'h00, 1'b1, reg_wdata[BIT_TEMP_SENSOR_ENABLE]};
            end
            if (wr_bg) begin
                bgen_ff <= reg_wdata[BIT_BGEN];
            end
        end
    end

    // Sticky events; a set in the same cycle as a write-one clear wins.
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_ff <= 2'h0;
            irq_mask_ff <= 2'h0;
        end else begin
            irq_stat_ff[IRQ_DONE] <= conv_end
                || (irq_stat_ff[IRQ_DONE] && !(wr_stat && reg_wdata[IRQ_DONE]));
            irq_stat_ff[IRQ_BAD_SRC] <= bad_src
                || (irq_stat_ff[IRQ_BAD_SRC] && !(wr_stat && reg_wdata[IRQ_BAD_SRC]));
            if (wr_mask) begin
                irq_mask_ff <= reg_wdata[1:0];
            end
        end
    end

    // Named steps of the start handshake.
    sequence s_start_done;
        start_done && converter_enable && !conv_busy_flag;
    endsequence

    a_busy_after_start: assert property (@(posedge mclk) disable iff (!arst_n)
        s_start_done |=> conv_busy_flag)
        else $error("busy did not rise after start completed");
    a_no_start_without_seq: assert property (@(posedge mclk) disable iff (!arst_n)
        $rose(conv_busy_flag) |-> $past(start_done))
        else $error("conversion began without a completed start sequence");
    a_result_same_cycle: assert property (@(posedge mclk) disable iff (!arst_n)
        $fell(conv_busy_flag) && $past(converter_enable) |-> result_ff == $past(sar_ff))
        else $error("result not updated as busy cleared");
    a_result_held_off: assert property (@(posedge mclk) disable iff (!arst_n)
        !$past(converter_enable) |-> $stable(result_ff))
        else $error("result changed while converter disabled");
    a_align_zero_bits: assert property (@(posedge mclk) disable iff (!arst_n)
        result_alignment_sel |-> res_high[7:4] == 4'h0)
        else $error("unused high-byte bits not zero");
    a_align_low_zero: assert property (@(posedge mclk) disable iff (!arst_n)
        !result_alignment_sel |-> res_low[3:0] == 4'h0 && res_high == result_ff[11:4])
        else $error("left-aligned layout wrong");
    a_read_latency: assert property (@(posedge mclk) disable iff (!arst_n)
        reg_rd && reg_addr == OFS_RESULT_HIGH |=> reg_rdata == $past(res_high))
        else $error("high byte read data wrong");
    a_float_pins: assert property (@(posedge mclk) disable iff (!arst_n)
        external_channel_sel[3] || !src_is_ext |-> ext_pin_sel == 8'h00)
        else $error("pin routed for floating or internal selection");
    a_forbidden_src: assert property (@(posedge mclk) disable iff (!arst_n)
        bad_src |=> input_source_sel == $past(input_source_sel))
        else $error("forbidden source code was stored");
    a_power_follows: assert property (@(posedge mclk) disable iff (!arst_n)
        wr_main |=> conv_power_on == $past(reg_wdata[BIT_ENABLE]))
        else $error("power did not follow enable write");
endmodule

// >>> tb/tb_top.sv
// Self-checking bench for the converter control registers, driven over the plain register port.
module tb_top;
    import adc_ctrl_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic comp_in = 1'b0;
    logic [7:0] reg_rdata;
    logic irq, conv_power_on, sample_hold, low_current_mode, temp_sensor_enable, bandgap_enable;
    logic [7:0] ext_pin_sel;
    logic [3:0] int_src_sel;
    logic [2:0] ref_sel;
    int n_fail = 0;
    int n_tests = 0;
    int cyc = 0;

    adc_control_regs i_adc_control_regs (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .conv_power_on(conv_power_on), .sample_hold(sample_hold), .comp_in(comp_in),
        .ext_pin_sel(ext_pin_sel), .int_src_sel(int_src_sel), .ref_sel(ref_sel),
        .low_current_mode(low_current_mode), .temp_sensor_enable(temp_sensor_enable),
        .bandgap_enable(bandgap_enable)
    );

    // The clock runs at 100 MHz.
    initial begin
        forever #5 mclk = ~mclk;
    end

    // Cycle counter; the ceiling is far above the longest conversion used, so a hang ends the run.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [11:0] exp, input logic [11:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One-cycle write strobe; the strobe drops at the next edge so calls never overlap.
    // The short wait lets the register update of the taking edge settle before any pin check.
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe, so they are taken just after that edge.
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask

    task automatic rd_chk(input string name, input logic [2:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(name, {4'h0, exp}, {4'h0, d});
    endtask

    task automatic t_reset_values();
        rd_chk("main_rst", OFS_CONTROL_MAIN, 8'h00);
        rd_chk("src_rst", OFS_SOURCE_CLOCK, 8'h00);
        rd_chk("mode_rst", OFS_MODE_SENSOR, 8'h02);
        rd_chk("bg_rst", OFS_BANDGAP, 8'h00);
        rd_chk("low_rst", OFS_RESULT_LOW, 8'h00);
    endtask

    // Every channel code, then every legal source code with channel 2 held, each paired with a reference code so all four are covered.
    task automatic t_routing();
        logic [7:0] exp_pin;
        logic [3:0] exp_int;
        logic [2:0] exp_ref;
        for (int c = 0; c < 16; c++) begin
            wr(OFS_CONTROL_MAIN, 8'(c));
            exp_pin = (c < 8) ? 8'h01 << c : 8'h00;
            chk("ext_pin_sel", {4'h0, exp_pin}, {4'h0, ext_pin_sel});
        end
        wr(OFS_CONTROL_MAIN, 8'h02);
        for (int s = 0; s < 7; s++) begin
            wr(OFS_SOURCE_CLOCK, 8'(s << 5) | 8'(s & 3) << 3);
            exp_int = (s >= 1 && s <= 4) ? 4'h1 << (s - 1) : 4'h0;
            exp_pin = (s == 0 || s >= 5) ? 8'h04 : 8'h00;
            exp_ref = ((s & 3) == 0) ? 3'b001 : ((s & 3) == 2) ? 3'b010 : 3'b100;
            chk("int_src_sel", {8'h00, exp_int}, {8'h00, int_src_sel});
            chk("ext_route", {4'h0, exp_pin}, {4'h0, ext_pin_sel});
            chk("ref_sel", {9'h000, exp_ref}, {9'h000, ref_sel});
            rd_chk("src_rb", OFS_SOURCE_CLOCK, 8'(s << 5) | 8'(s & 3) << 3);
        end
    endtask

    // Forbidden source code is dropped and flagged; the unmasked flag raises the line until a write-one clear drops it.
    task automatic t_forbidden_irq();
        wr(OFS_SOURCE_CLOCK, 8'h0B);
        wr(OFS_IRQ_MASK, 8'h02);
        wr(OFS_SOURCE_CLOCK, 8'hE0);
        rd_chk("src_kept", OFS_SOURCE_CLOCK, 8'h0B);
        rd_chk("status_bad", OFS_IRQ_STATUS, 8'h02);
        chk("irq_on", 12'h001, {11'h000, irq});
        wr(OFS_IRQ_STATUS, 8'h02);
        chk("irq_off", 12'h000, {11'h000, irq});
        wr(OFS_SOURCE_CLOCK, 8'h00);
    endtask

    task automatic t_mode_bits();
        wr(OFS_MODE_SENSOR, 8'hFD);
        rd_chk("mode_rb", OFS_MODE_SENSOR, 8'h83);
        chk("mode_pins", 12'h003, {10'h000, low_current_mode, temp_sensor_enable});
        wr(OFS_BANDGAP, 8'hFF);
        rd_chk("bg_rb", OFS_BANDGAP, 8'h01);
        chk("bg_pin", 12'h001, {11'h000, bandgap_enable});
        wr(OFS_MODE_SENSOR, 8'h00);
        chk("mode_clr", 12'h000, {10'h000, low_current_mode, temp_sensor_enable});
    endtask

    // Start only after high then low; busy stands for 16 divided ticks; results land at busy fall.
    task automatic t_convert(input logic cmp, input logic [2:0] dv, input logic [11:0] res);
        logic [7:0] d;
        int t0;
        int n;
        comp_in <= cmp;
        wr(OFS_SOURCE_CLOCK, {5'h00, dv});
        wr(OFS_CONTROL_MAIN, 8'hA0);
        repeat (4) @(posedge mclk);
        rd(OFS_CONTROL_MAIN, d);
        chk("busy_half_seq", 12'h000, {11'h000, d[BIT_BUSY]});
        wr(OFS_CONTROL_MAIN, 8'h20);
        t0 = cyc;
        rd(OFS_CONTROL_MAIN, d);
        chk("busy_set", 12'h001, {11'h000, d[BIT_BUSY]});
        n = 0;
        while (d[BIT_BUSY] !== 1'b0 && n < 3000) begin
            rd(OFS_CONTROL_MAIN, d);
            n++;
        end
        n = cyc - t0;
        chk("conv_len", 12'h001, 12'((n >= (16 << dv)) && (n <= (17 << dv) + 8)));
        rd_chk("high_a0", OFS_RESULT_HIGH, res[11:4]);
        rd_chk("low_a0", OFS_RESULT_LOW, {res[3:0], 4'h0});
        wr(OFS_CONTROL_MAIN, 8'h30);
        rd_chk("high_a1", OFS_RESULT_HIGH, {4'h0, res[11:8]});
        rd_chk("low_a1", OFS_RESULT_LOW, res[7:0]);
        rd_chk("status_done", OFS_IRQ_STATUS, 8'h01);
        chk("irq_done", 12'h001, {11'h000, irq});
        wr(OFS_IRQ_STATUS, 8'h01);
    endtask

    // Busy ignores writes, disabled start is ignored, and clearing enable keeps the old result.
    task automatic t_abort();
        logic [7:0] d;
        wr(OFS_CONTROL_MAIN, 8'h40);
        rd_chk("busy_ro", OFS_CONTROL_MAIN, 8'h00);
        chk("power_off", 12'h000, {11'h000, conv_power_on});
        wr(OFS_CONTROL_MAIN, 8'h80);
        wr(OFS_CONTROL_MAIN, 8'h00);
        rd(OFS_CONTROL_MAIN, d);
        chk("busy_disabled", 12'h000, {11'h000, d[BIT_BUSY]});
        comp_in <= 1'b0;
        wr(OFS_SOURCE_CLOCK, 8'h07);
        wr(OFS_CONTROL_MAIN, 8'hA0);
        wr(OFS_CONTROL_MAIN, 8'h20);
        chk("power_on", 12'h001, {11'h000, conv_power_on});
        chk("sample_start", 12'h001, {11'h000, sample_hold});
        repeat (100) @(posedge mclk);
        #1;
        chk("sample_mid", 12'h001, {11'h000, sample_hold});
        wr(OFS_CONTROL_MAIN, 8'h00);
        repeat (2200) @(posedge mclk);
        rd_chk("busy_abort", OFS_CONTROL_MAIN, 8'h00);
        rd_chk("high_kept", OFS_RESULT_HIGH, 8'hFF);
        rd_chk("low_kept", OFS_RESULT_LOW, 8'hF0);
    endtask

    // Reset is held for six cycles, then the scenarios run in turn.
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset_values();
        t_routing();
        t_forbidden_irq();
        t_mode_bits();
        wr(OFS_IRQ_MASK, 8'h01);
        t_convert(1'b1, 3'h0, 12'hFFF);
        t_convert(1'b0, 3'h3, 12'h000);
        t_convert(1'b1, 3'h1, 12'hFFF);
        t_abort();
        print_verdict();
    end
endmodule
